// [common/flash_host_pkg.sv]
package flash_host_pkg;
    // Command encodings
    localparam logic [3:0] OP_READ       = 4'h0;
    localparam logic [3:0] OP_PROGRAM    = 4'h1;
    localparam logic [3:0] OP_BYP_ENTER  = 4'h2;
    localparam logic [3:0] OP_BYP_PROG   = 4'h3;
    localparam logic [3:0] OP_BYP_EXIT   = 4'h4;
    localparam logic [3:0] OP_CHIP_ERASE = 4'h5;
    localparam logic [3:0] OP_SECT_ERASE = 4'h6;
    localparam logic [3:0] OP_SECT_MORE  = 4'h7;
    localparam logic [3:0] OP_SEC_ENTER  = 4'h8;
    localparam logic [3:0] OP_SEC_EXIT   = 4'h9;
    localparam logic [3:0] OP_HW_RESET   = 4'hA;

    // Wishbone register offsets
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_ADDR   = 4'h4;
    localparam logic [3:0] REG_WDATA  = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hC;

    // Control register fields
    localparam int CTRL_OP_LSB  = 0;
    localparam int CTRL_ACC_BIT = 8;
    localparam int CTRL_GO_BIT  = 31;

    // Status register fields
    localparam int ST_BUSY_BIT   = 0;
    localparam int ST_RDY_BIT    = 1;
    localparam int ST_SEC_BIT    = 2;
    localparam int ST_BYP_BIT    = 3;
    localparam int ST_ACC_BIT    = 4;
    localparam int ST_TOG_BIT    = 5;
    localparam int ST_TLIM_BIT   = 6;
    localparam int ST_ETMR_BIT   = 7;
    localparam int ST_DATA_LSB   = 16;

    // Unlock and command values, kept from the device command table
    localparam logic [23:0] UNLOCK1_ADDR   = 24'h000555;
    localparam logic [23:0] UNLOCK2_ADDR   = 24'h0002AA;
    localparam logic [31:0] UNLOCK1_DATA   = 32'h000000AA;
    localparam logic [31:0] UNLOCK2_DATA   = 32'h00000055;
    localparam logic [31:0] CMD_PROG       = 32'h000000A0;
    localparam logic [31:0] CMD_BYPASS     = 32'h00000020;
    localparam logic [31:0] CMD_BYP_RST1   = 32'h00000090;
    localparam logic [31:0] CMD_BYP_RST2   = 32'h00000000;
    localparam logic [31:0] CMD_ERASE_SET  = 32'h00000080;
    localparam logic [31:0] CMD_CHIP_ERASE = 32'h00000010;
    localparam logic [31:0] CMD_SECT_ERASE = 32'h00000030;
    localparam logic [31:0] CMD_SEC_ENTER  = 32'h00000088;
    localparam logic [31:0] CMD_SEC_EXIT1  = 32'h00000090;
    localparam logic [31:0] CMD_SEC_EXIT2  = 32'h00000000;

    // Bus timing
    localparam int CLK_MHZ          = 100;
    localparam int STROBE_NS        = 50;
    localparam int SETUP_NS         = 30;
    localparam int ACCUM_US         = 80;
    localparam int STROBE_CYC       = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int SETUP_CYC        = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int ACCUM_CYC        = ACCUM_US * CLK_MHZ;
    localparam int RESET_NS         = 500;
    localparam int RESET_CYC        = (RESET_NS * CLK_MHZ + 999) / 1000;

    typedef struct packed {
        logic [23:0] addr;
        logic [31:0] wdata;
        logic        we_n;
        logic        ce_n;
        logic        oe_n;
        logic        dq_oe;
        logic        reset_n;
        logic        acc_high;
        logic        word_mode_n;
    } flash_pins_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic        ready_busy_pin;
    } flash_in_t;

    typedef struct packed {
        logic [31:0] dat;
        logic        ack;
    } wb_resp_t;
endpackage : flash_host_pkg

// [logic/flash_bus_cycle.sv]
`timescale 1ns/10ps
// One flash write or read: address set, CE and WE/OE low, strobe width, release.
module flash_bus_cycle
    import flash_host_pkg::*;
#(
    parameter int STROBE = STROBE_CYC,
    parameter int SETUP  = SETUP_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        start_i,
    input  wire logic        write_i,
    input  wire logic [23:0] addr_i,
    input  wire logic [31:0] data_i,
    input  wire logic [31:0] rdata_i,
    output logic             done_o,
    output logic [31:0]      rdata_o,
    output logic [23:0]      addr_o,
    output logic [31:0]      wdata_o,
    output logic             we_n_o,
    output logic             ce_n_o,
    output logic             oe_n_o,
    output logic             dq_oe_o
);
    typedef enum {C_IDLE, C_SETUP, C_STROBE, C_HOLD} cyc_state_t;
    typedef struct packed {
        cyc_state_t  st;
        logic [7:0]  cnt;
        logic        wr;
        logic        done;
        logic [31:0] rd;
        logic [23:0] a;
        logic [31:0] d;
        logic        we_n;
        logic        ce_n;
        logic        oe_n;
        logic        dq_oe;
    } cyc_t;
    cyc_t s, next_s;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        unique case (s.st)
            C_IDLE: begin
                if (start_i) begin
                    next_s.st = C_SETUP;
                    next_s.wr = write_i;
                    next_s.a = addr_i;
                    next_s.d = data_i;
                    next_s.ce_n = 1'b0;
                    next_s.dq_oe = write_i;
                    next_s.cnt = 8'(SETUP);
                end
            end
            C_SETUP: begin
                if (s.cnt <= 8'h01) begin
                    // Address is latched by the device on this falling strobe edge
                    next_s.st = C_STROBE;
                    next_s.we_n = ~s.wr;
                    next_s.oe_n = s.wr;
                    next_s.cnt = 8'(STROBE);
                end else begin
                    next_s.cnt = s.cnt - 8'h01;
                end
            end
            C_STROBE: begin
                if (s.cnt <= 8'h01) begin
                    // WE rises before CE so data is taken on the WE edge
                    next_s.st = C_HOLD;
                    next_s.we_n = 1'b1;
                    next_s.oe_n = 1'b1;
                    next_s.rd = rdata_i;
                end else begin
                    next_s.cnt = s.cnt - 8'h01;
                end
            end
            C_HOLD: begin
                next_s.st = C_IDLE;
                next_s.ce_n = 1'b1;
                next_s.dq_oe = 1'b0;
                next_s.done = 1'b1;
            end
            default: next_s.st = C_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '{st: C_IDLE, cnt: 8'h00, wr: 1'b0, done: 1'b0, rd: 32'h00000000,
                   a: 24'h000000, d: 32'h00000000, we_n: 1'b1, ce_n: 1'b1,
                   oe_n: 1'b1, dq_oe: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign done_o  = s.done;
    assign rdata_o = s.rd;
    assign addr_o  = s.a;
    assign wdata_o = s.d;
    assign we_n_o  = s.we_n;
    assign ce_n_o  = s.ce_n;
    assign oe_n_o  = s.oe_n;
    assign dq_oe_o = s.dq_oe;
endmodule : flash_bus_cycle

// [logic/flash_host_ctrl.sv]
`timescale 1ns/10ps
module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter int ACCUM_CYCLES = ACCUM_CYC
) (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic [3:0]                wb_adr_i,
    input  wire logic [31:0]               wb_dat_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic                      wb_we_i,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    output flash_host_pkg::wb_resp_t       wb_o,
    input  wire flash_host_pkg::flash_in_t flash_i,
    output flash_host_pkg::flash_pins_t    flash_o
);
    import flash_host_pkg::*;

    typedef enum {S_IDLE, S_ISSUE, S_WAIT, S_POLL, S_WINDOW, S_RESET} host_state_t;

    typedef struct packed {
        host_state_t st;
        logic [3:0]  op;
        logic [2:0]  step;
        logic [23:0] addr;
        logic [31:0] wdata;
        logic        acc;
        logic        sec;
        logic        byp;
        logic [15:0] tmr;
        logic        tmr_done;
        logic        tog_prev;
        logic        toggling;
        logic        tlim;
        logic        ack;
        logic [31:0] dat;
        logic        rst_n;
        logic        start;
        logic        err;
    } host_t;
    host_t s, next_s;

    logic        cyc_done;
    logic [31:0] cyc_rdata;
    logic [23:0] pin_addr;
    logic [31:0] pin_wdata;
    logic        pin_we_n;
    logic        pin_ce_n;
    logic        pin_oe_n;
    logic        pin_dq_oe;
    logic [23:0] cyc_addr;
    logic [31:0] cyc_data;
    logic        cyc_write;
    logic [2:0]  seq_len;
    logic        busy;

    flash_bus_cycle u_cycle (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (s.start),
        .write_i (cyc_write),
        .addr_i  (cyc_addr),
        .data_i  (cyc_data),
        .rdata_i (flash_i.rdata),
        .done_o  (cyc_done),
        .rdata_o (cyc_rdata),
        .addr_o  (pin_addr),
        .wdata_o (pin_wdata),
        .we_n_o  (pin_we_n),
        .ce_n_o  (pin_ce_n),
        .oe_n_o  (pin_oe_n),
        .dq_oe_o (pin_dq_oe)
    );

    assign busy = (s.st != S_IDLE) && (s.st != S_WINDOW);

    // Write table: one entry per step of each command sequence
    always_comb begin
        cyc_write = 1'b1;
        cyc_addr  = UNLOCK1_ADDR;
        cyc_data  = UNLOCK1_DATA;
        seq_len   = 3'd1;
        unique case (s.op)
            OP_PROGRAM, OP_BYP_ENTER, OP_SEC_ENTER: begin
                seq_len = (s.op == OP_PROGRAM) ? 3'd4 : 3'd3;
                unique case (s.step)
                    3'd0: begin cyc_addr = UNLOCK1_ADDR; cyc_data = UNLOCK1_DATA; end
                    3'd1: begin cyc_addr = UNLOCK2_ADDR; cyc_data = UNLOCK2_DATA; end
                    3'd2: begin
                        cyc_addr = UNLOCK1_ADDR;
                        cyc_data = (s.op == OP_PROGRAM) ? CMD_PROG :
                                   (s.op == OP_BYP_ENTER) ? CMD_BYPASS : CMD_SEC_ENTER;
                    end
                    default: begin cyc_addr = s.addr; cyc_data = s.wdata; end
                endcase
            end
            OP_SEC_EXIT: begin
                seq_len = 3'd4;
                unique case (s.step)
                    3'd0: begin cyc_addr = UNLOCK1_ADDR; cyc_data = UNLOCK1_DATA; end
                    3'd1: begin cyc_addr = UNLOCK2_ADDR; cyc_data = UNLOCK2_DATA; end
                    3'd2: begin cyc_addr = UNLOCK1_ADDR; cyc_data = CMD_SEC_EXIT1; end
                    default: begin cyc_addr = s.addr; cyc_data = CMD_SEC_EXIT2; end
                endcase
            end
            OP_BYP_PROG: begin
                seq_len = 3'd2;
                cyc_addr = s.addr;
                cyc_data = (s.step == 3'd0) ? CMD_PROG : s.wdata;
            end
            OP_BYP_EXIT: begin
                seq_len = 3'd2;
                cyc_addr = s.addr;
                cyc_data = (s.step == 3'd0) ? CMD_BYP_RST1 : CMD_BYP_RST2;
            end
            OP_CHIP_ERASE, OP_SECT_ERASE: begin
                seq_len = 3'd6;
                unique case (s.step)
                    3'd0, 3'd3: begin cyc_addr = UNLOCK1_ADDR; cyc_data = UNLOCK1_DATA; end
                    3'd1, 3'd4: begin cyc_addr = UNLOCK2_ADDR; cyc_data = UNLOCK2_DATA; end
                    3'd2: begin cyc_addr = UNLOCK1_ADDR; cyc_data = CMD_ERASE_SET; end
                    default: begin
                        cyc_addr = (s.op == OP_SECT_ERASE) ? s.addr : UNLOCK1_ADDR;
                        cyc_data = (s.op == OP_SECT_ERASE) ? CMD_SECT_ERASE : CMD_CHIP_ERASE;
                    end
                endcase
            end
            OP_SECT_MORE: begin
                cyc_addr = s.addr;
                cyc_data = CMD_SECT_ERASE;
            end
            default: begin
                cyc_write = 1'b0;
                cyc_addr  = s.addr;
            end
        endcase
    end

    always_comb begin
        next_s = s;
        next_s.ack = 1'b0;
        next_s.start = 1'b0;
        // Wishbone slave, single-cycle answer, ack drops after one cycle
        if (wb_cyc_i && wb_stb_i && !s.ack) begin
            next_s.ack = 1'b1;
            unique case (wb_adr_i)
                REG_CTRL: begin
                    next_s.dat = {23'h000000, s.acc, 4'h0, s.op};
                    if (wb_we_i && wb_sel_i[0]) begin
                        next_s.acc = wb_dat_i[CTRL_ACC_BIT];
                        next_s.byp = s.byp | wb_dat_i[CTRL_ACC_BIT];
                    end
                    // Orders are refused while a device operation runs
                    if (wb_we_i && wb_dat_i[CTRL_GO_BIT] && !busy) begin
                        next_s.err = 1'b0;
                        next_s.op = wb_dat_i[CTRL_OP_LSB +: 4];
                        next_s.step = 3'd0;
                        next_s.st = S_ISSUE;
                        if (wb_dat_i[CTRL_OP_LSB +: 4] == OP_HW_RESET) begin
                            next_s.st = S_RESET;
                            next_s.tmr = 16'(RESET_CYC);
                            next_s.rst_n = 1'b0;
                        end else if (s.st == S_WINDOW &&
                                     wb_dat_i[CTRL_OP_LSB +: 4] != OP_SECT_MORE) begin
                            next_s.tmr_done = 1'b1;
                        end else if (s.byp && wb_dat_i[CTRL_OP_LSB +: 4] != OP_BYP_PROG &&
                                     wb_dat_i[CTRL_OP_LSB +: 4] != OP_BYP_EXIT) begin
                            next_s.st = S_IDLE;
                            next_s.err = 1'b1;
                        end
                    end
                end
                REG_ADDR: begin
                    next_s.dat = {8'h00, s.addr};
                    if (wb_we_i) next_s.addr = wb_dat_i[23:0];
                end
                REG_WDATA: begin
                    next_s.dat = s.wdata;
                    if (wb_we_i) next_s.wdata = wb_dat_i;
                end
                default: begin
                    next_s.dat = {cyc_rdata[15:0], 7'h00, s.err, s.tmr_done, s.tlim,
                                  s.toggling, s.acc, s.byp, s.sec,
                                  flash_i.ready_busy_pin, busy};
                end
            endcase
        end
        unique case (s.st)
            S_IDLE: ;
            S_ISSUE: begin
                next_s.start = 1'b1;
                next_s.st = S_WAIT;
            end
            S_WAIT: begin
                if (cyc_done) begin
                    if (s.step + 3'd1 < seq_len) begin
                        next_s.step = s.step + 3'd1;
                        next_s.st = S_ISSUE;
                    end else if (s.op == OP_SECT_ERASE || s.op == OP_SECT_MORE) begin
                        next_s.st = S_WINDOW;
                        next_s.tmr = 16'(ACCUM_CYCLES);
                        next_s.tmr_done = 1'b0;
                    end else begin
                        if (s.op == OP_SEC_ENTER) next_s.sec = 1'b1;
                        if (s.op == OP_SEC_EXIT) next_s.sec = 1'b0;
                        if (s.op == OP_BYP_ENTER) next_s.byp = 1'b1;
                        if (s.op == OP_BYP_EXIT) next_s.byp = s.acc;
                        next_s.st = (s.op == OP_PROGRAM || s.op == OP_BYP_PROG ||
                                     s.op == OP_CHIP_ERASE) ? S_POLL : S_IDLE;
                        next_s.toggling = 1'b1;
                    end
                end
            end
            S_WINDOW: begin
                // An order taken this cycle has already closed the window; keep its state
                if (next_s.st == S_WINDOW) begin
                    if (s.tmr == 16'h0000) begin
                        next_s.tmr_done = 1'b1;
                        next_s.st = S_POLL;
                    end else begin
                        next_s.tmr = s.tmr - 16'h0001;
                    end
                end
            end
            S_POLL: begin
                // Toggle bit stops once the device returns to read
                if (cyc_done) begin
                    next_s.tog_prev = cyc_rdata[6];
                    next_s.toggling = (cyc_rdata[6] != s.tog_prev);
                    next_s.tlim = cyc_rdata[5];
                    if (cyc_rdata[6] == s.tog_prev && flash_i.ready_busy_pin)
                        next_s.st = S_IDLE;
                end else if (pin_ce_n && !s.start) begin
                    next_s.op = OP_READ;
                    next_s.start = 1'b1;
                end
            end
            S_RESET: begin
                if (s.tmr == 16'h0000) begin
                    next_s.rst_n = 1'b1;
                    next_s.sec = 1'b0;
                    next_s.byp = s.acc;
                    next_s.st = S_IDLE;
                end else begin
                    next_s.tmr = s.tmr - 16'h0001;
                end
            end
            default: next_s.st = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '{st: S_IDLE, op: OP_READ, step: 3'd0, addr: 24'h000000,
                   wdata: 32'h00000000, acc: 1'b0, sec: 1'b0, byp: 1'b0,
                   tmr: 16'h0000, tmr_done: 1'b0, tog_prev: 1'b0, toggling: 1'b0,
                   tlim: 1'b0, ack: 1'b0, dat: 32'h00000000, rst_n: 1'b1,
                   start: 1'b0, err: 1'b0};
            flash_o <= '{addr: 24'h000000, wdata: 32'h00000000, we_n: 1'b1, ce_n: 1'b1,
                         oe_n: 1'b1, dq_oe: 1'b0, reset_n: 1'b0, acc_high: 1'b0,
                         word_mode_n: 1'b0};
        end else begin
            s <= next_s;
            flash_o <= '{addr: pin_addr, wdata: pin_wdata, we_n: pin_we_n,
                         ce_n: pin_ce_n, oe_n: pin_oe_n, dq_oe: pin_dq_oe,
                         reset_n: s.rst_n, acc_high: s.acc, word_mode_n: 1'b0};
        end
    end

    assign wb_o = '{dat: s.dat, ack: s.ack};
endmodule : flash_host_ctrl

// [testbench/flash_dev_model.sv]
`timescale 1ns/10ps
module flash_dev_model #(
    parameter int WIN = 8000
) (
    input  wire logic                  clk_i,
    input  wire flash_host_pkg::flash_pins_t pins_i,
    output flash_host_pkg::flash_in_t  pins_o
);
    import flash_host_pkg::*;
    logic [31:0] mem [16];
    logic [31:0] r;
    logic [3:0]  st, sm;
    logic [7:0]  tm;
    logic [15:0] win;
    logic        byp, sec, tg, pw;
    wire  [31:0] d = pins_i.wdata;
    wire  [23:0] a = pins_i.addr;
    wire         busy = tm != 0;
    assign pins_o = {r, !busy};
    initial begin
        foreach (mem[i]) mem[i] = '1;
        {r, tg, pw, tm, win} = '0;
    end
    always @(posedge clk_i) begin
        pw <= pins_i.we_n;
        tg <= busy ? !tg : tg;
        // Released bus shows the inverse, so a stale sample never passes
        r <= (pins_i.oe_n || pins_i.ce_n) ? ~r
            : (busy && (sm == 4'h0 || sm[a[3:2]])) ? {25'h0, tg, 6'h0}
            : sec ? {8'h5E, a} : mem[a[3:0]];
        if (tm != 0) tm <= tm - 8'd1;
        // Erase ends with the busy count, so a later busy period shows status at every address again
        if (tm == 8'd1) sm <= 4'h0;
        if (win != 0) win <= win - 16'd1;
        if (win == 16'd1) begin
            tm <= 8'd60;
            foreach (mem[i]) if (sm[i/4]) mem[i] <= '1;
        end
        if (pins_i.we_n && !pw && !busy) begin
            st <= 0;
            if (win != 0) begin
                if (d == CMD_SECT_ERASE) begin sm[a[3:2]] <= 1; win <= 16'(WIN); end
                else begin win <= 0; sm <= 0; end
            end else if (st == (byp ? 4'd1 : 4'd3)) begin
                mem[a[3:0]] <= mem[a[3:0]] & d;
                tm <= 8'd30;
            end else if (byp) begin
                if (d == CMD_PROG) st <= 1;
                else if (d == CMD_BYP_RST1) st <= 9;
                else if (st == 9 && d == CMD_BYP_RST2) byp <= 0;
            end else if ((st == 0 || st == 4) && a == UNLOCK1_ADDR && d == UNLOCK1_DATA)
                st <= st + 4'd1;
            else if ((st == 1 || st == 5) && a == UNLOCK2_ADDR && d == UNLOCK2_DATA)
                st <= st + 4'd1;
            else if (st == 2) begin
                if (d == CMD_PROG) st <= 3;
                if (d == CMD_ERASE_SET) st <= 4;
                if (d == CMD_SEC_EXIT1) st <= 8;
                if (d == CMD_BYPASS) byp <= 1;
                if (d == CMD_SEC_ENTER) sec <= 1;
            end else if (st == 6 && d == CMD_CHIP_ERASE) begin
                foreach (mem[i]) mem[i] <= '1;
                tm <= 8'd60;
            end else if (st == 6 && d == CMD_SECT_ERASE) begin
                sm <= 4'h1 << a[3:2];
                win <= 16'(WIN);
            end else if (st == 8 && d == CMD_SEC_EXIT2) sec <= 0;
        end
        if (pins_i.acc_high) byp <= 1;
        if (!pins_i.reset_n) {tm, st, sm, win, byp, sec} <= '0;
    end
endmodule : flash_dev_model

// [testbench/flash_host_ctrl_asserts.sv]
`timescale 1ns/10ps
module flash_host_ctrl_asserts #(
    parameter int ACCUM_CYCLES = 8000
) (
    input wire logic                        clk_i,
    input wire logic                        rst_i,
    input wire logic                        wb_cyc_i,
    input wire logic                        wb_stb_i,
    input wire flash_host_pkg::wb_resp_t    wb_o,
    input wire flash_host_pkg::flash_in_t   flash_i,
    input wire flash_host_pkg::flash_pins_t flash_o
);
    import flash_host_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_o.ack |=> wb_o.ack)
        else $error("bus request not answered next cycle");
    ack_pulse_a: assert property (wb_o.ack |=> !wb_o.ack)
        else $error("ack held too long");
    reset_idle_a: assert property ($fell(rst_i) |-> !flash_o.reset_n && flash_o.we_n
        && flash_o.ce_n && !flash_o.dq_oe && !wb_o.ack) else $error("pins not idle at reset");
    strobe_select_a: assert property (!flash_o.we_n |-> !flash_o.ce_n && flash_o.dq_oe)
        else $error("write strobe without select or data");
    read_release_a: assert property (!flash_o.oe_n |-> !flash_o.dq_oe && flash_o.we_n)
        else $error("host drives data while reading");
    strobe_width_a: assert property ($fell(flash_o.we_n) |-> (!flash_o.we_n)[*5])
        else $error("write strobe too short");
    hold_stable_a: assert property (!flash_o.we_n && !$past(flash_o.we_n)
        |-> $stable(flash_o.addr) && $stable(flash_o.wdata)) else $error("bus moved in strobe");
    ce_release_a: assert property ($rose(flash_o.we_n) |-> !flash_o.ce_n ##1 flash_o.ce_n)
        else $error("select not released after strobe");
    busy_quiet_a: assert property ($fell(flash_o.we_n) |-> flash_i.ready_busy_pin)
        else $error("write while device busy");

    cover property ($fell(flash_i.ready_busy_pin));
    cover property (flash_o.acc_high && $fell(flash_o.we_n));
    cover property ($fell(flash_o.reset_n));
endmodule : flash_host_ctrl_asserts

bind flash_host_ctrl flash_host_ctrl_asserts #(.ACCUM_CYCLES(ACCUM_CYCLES))
    i_flash_host_ctrl_asserts (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_o(wb_o), .flash_i(flash_i), .flash_o(flash_o));

// [testbench/tb_flash_host_ctrl.sv]
`timescale 1ns/10ps
module tb_flash_host_ctrl;
    import flash_host_pkg::*;
    logic        clk_i, rst_i, cyc, stb, we;
    logic [3:0]  adr;
    logic [31:0] dat, q;
    int          n_fail, comparisons;
    wb_resp_t    wb_o;
    flash_in_t   fi;
    flash_pins_t fo;

    flash_host_ctrl #(.ACCUM_CYCLES(200)) i_flash_host_ctrl (.clk_i(clk_i), .rst_i(rst_i),
        .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_o(wb_o), .flash_i(fi), .flash_o(fo));
    // Device window a little shorter than the host's, as a real part may be
    flash_dev_model #(.WIN(180)) i_flash_dev_model (.clk_i(clk_i), .pins_i(fo), .pins_o(fi));

    initial begin
        clk_i = 0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic final_report;
        if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
        int n;
        {adr, we, dat, cyc, stb} <= {a, w, d, 2'b11};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_o.ack !== 1'b1 && n < 20);
        q = wb_o.dat;
        {cyc, stb, we} <= 3'b000;
        @(posedge clk_i);
        if (n >= 20) begin
            n_fail++;
            $display("[ERR] %0t no bus answer", $time);
            final_report();
        end
    endtask : wb

    task automatic run(input logic [3:0] op, input logic [23:0] a, input logic [31:0] d,
                       input logic acc);
        int n;
        wb(REG_ADDR, 1, {8'h00, a});
        wb(REG_WDATA, 1, d);
        wb(REG_CTRL, 1, (32'h1 << CTRL_GO_BIT) | (32'(acc) << CTRL_ACC_BIT) | 32'(op));
        n = 0;
        do begin
            wb(REG_STATUS, 0, 0);
            n++;
        // An added sector leaves the host in its window, which is not busy: wait for expiry
        end while ((q[ST_BUSY_BIT] !== 1'b0 ||
                    (op == OP_SECT_MORE && q[ST_ETMR_BIT] !== 1'b1)) && n < 500);
        if (n >= 500) begin
            n_fail++;
            $display("[ERR] %0t operation never finished", $time);
            final_report();
        end
    endtask : run

    initial begin
        {cyc, stb, we, adr, dat, n_fail, comparisons} = '0;
        rst_i = 1;
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        wb(REG_STATUS, 0, 0);
        chk(q[1:0], 16'h2);
        wb(4'h2, 0, 0);
        chk(q[1:0], 16'h2);
        run(OP_PROGRAM, 24'h3, 32'hF0, 0);
        run(OP_READ, 24'h3, 0, 0);
        chk(q[31:16], 16'h00F0);
        run(OP_PROGRAM, 24'h3, 32'h0F, 0);
        run(OP_READ, 24'h3, 0, 0);
        chk(q[31:16], 16'h0000);
        run(OP_BYP_ENTER, 0, 0, 0);
        chk(q[ST_BYP_BIT], 1);
        run(OP_BYP_PROG, 24'h5, 32'h1234, 0);
        run(OP_PROGRAM, 24'h6, 32'h0, 0);
        chk(q[8], 1);
        run(OP_BYP_EXIT, 24'h5, 0, 0);
        chk(q[ST_BYP_BIT], 0);
        run(OP_READ, 24'h5, 0, 0);
        chk(q[31:16], 16'h1234);
        run(OP_READ, 24'h6, 0, 0);
        chk(q[31:16], 16'hFFFF);
        run(OP_CHIP_ERASE, 0, 0, 0);
        run(OP_READ, 24'h3, 0, 0);
        chk(q[31:16], 16'hFFFF);
        run(OP_PROGRAM, 24'h4, 32'h0, 0);
        run(OP_PROGRAM, 24'h8, 32'h0, 0);
        run(OP_SECT_ERASE, 24'h4, 0, 0);
        run(OP_SECT_MORE, 24'h8, 0, 0);
        chk(q[ST_ETMR_BIT], 1);
        run(OP_READ, 24'h4, 0, 0);
        chk(q[31:16], 16'hFFFF);
        run(OP_READ, 24'h8, 0, 0);
        chk(q[31:16], 16'hFFFF);
        run(OP_SEC_ENTER, 0, 0, 0);
        chk(q[ST_SEC_BIT], 1);
        run(OP_READ, 24'h3, 0, 0);
        chk(q[31:16], 16'h0003);
        run(OP_SEC_EXIT, 0, 0, 0);
        chk(q[ST_SEC_BIT], 0);
        run(OP_BYP_PROG, 24'h7, 32'hAB, 1);
        chk(q[ST_ACC_BIT], 1);
        run(OP_HW_RESET, 0, 0, 0);
        chk(q[ST_BYP_BIT], 0);
        run(OP_READ, 24'h7, 0, 0);
        chk(q[31:16], 16'h00AB);
        run(OP_PROGRAM, 24'h9, 32'h55, 0);
        run(OP_READ, 24'h9, 0, 0);
        chk(q[31:16], 16'h0055);
        final_report();
    end
endmodule : tb_flash_host_ctrl
